// ### answer_fifo.sv
// first-in first-out buffer with valid and ready on both sides
`timescale 1ns/1ns
module answer_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8,
  parameter int AW = $clog2(DEPTH)
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  typedef struct packed {
    logic [AW:0] wr;
    logic [AW:0] rd;
  } ptr_t;

  ptr_t st;
  ptr_t next_st;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push;
  logic pop;

  assign out_valid = (st.wr != st.rd);
  assign in_ready = (st.wr[AW-1:0] != st.rd[AW-1:0]) || (st.wr[AW] == st.rd[AW]);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[st.rd[AW-1:0]];

  always_comb begin
    next_st = st;
    if (push) begin
      next_st.wr = st.wr + (AW+1)'(1);
    end
    if (pop) begin
      next_st.rd = st.rd + (AW+1)'(1);
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // storage holds no control state, so it needs no reset
  always_ff @(posedge clock) begin
    if (push) begin
      mem[st.wr[AW-1:0]] <= in_data;
    end
  end

endmodule : answer_fifo

// ### decoder_port_model.sv
// behavioural model of the decoder's dual-mode serial control port
`timescale 1ns/1ns
module decoder_port_model (
  input wire logic sck,
  input wire logic sda,
  input wire logic serial_mode_select,
  input wire logic port_enable,
  input wire logic ack_on,
  input wire logic [7:0] tx_byte,
  output logic pull_low,
  output logic serial_out_pin,
  output logic [7:0] rx_byte,
  output logic [7:0] nbytes,
  output logic [3:0] starts,
  output logic [3:0] stops,
  output logic [3:0] resets,
  output logic [3:0] syncs
);
  logic [3:0] cnt;
  logic [7:0] sh;
  logic [3:0] ffs;
  logic so;
  logic live;
  time t0;
  initial {pull_low, rx_byte, nbytes, starts, stops, resets, syncs, cnt, sh, ffs, so, live, t0} = '0;
  // a disabled output is not driven: show the opposite of its last level
  assign serial_out_pin = (serial_mode_select && port_enable) ? so : !so;
  // wait for both pins to settle, as they move on the same clock edge
  always @(negedge sda) begin
    #1;
    if (!serial_mode_select && port_enable && sck) begin
      live = 1'b1;
      cnt = 4'h0;
      starts++;
    end
  end
  always @(posedge sda) begin
    #1;
    if (!serial_mode_select && sck && live) begin
      live = 1'b0;
      stops++;
    end
  end
  always @(posedge sck) begin
    if (serial_mode_select ? port_enable : live) begin
      if (cnt < 4'h8) sh = {sh[6:0], sda};
      cnt++;
      if (cnt == 4'h8) begin
        rx_byte = sh;
        nbytes++;
        if (sh == 8'hFF && ffs != 4'hF) ffs++;
        else begin
          if (sh == 8'hFE && ffs >= 4'h2) syncs++;
          ffs = 4'h0;
        end
      end
      if (cnt == (serial_mode_select ? 4'h8 : 4'h9)) cnt = 4'h0;
    end
  end
  always @(negedge sck) begin
    if (!serial_mode_select && live) pull_low = (cnt == 4'h8) && ack_on;
    if (serial_mode_select && port_enable) so = tx_byte[3'h7 - cnt[2:0]];
  end
  always @(posedge port_enable) begin
    if (serial_mode_select) begin
      cnt = 4'h0;
      ffs = 4'h0;
      so = tx_byte[7];
    end
  end
  always @(port_enable, serial_mode_select) begin
    if (!port_enable && !serial_mode_select) t0 = $time;
    else if (t0 != 0) begin
      if ($time - t0 >= 100) begin
        resets++;
        {live, cnt, ffs, pull_low} = '0;
      end
      t0 = 0;
    end
  end
endmodule : decoder_port_model

// ### quarter_timer.sv
// quarter-bit tick generator for the serial clock divider
`timescale 1ns/1ns
module quarter_timer #(
  parameter int QUARTER = 50
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic run,
  output logic tick
);

  typedef struct packed {
    logic [15:0] count;
  } timer_t;

  timer_t st;
  timer_t next_st;

  always_comb begin
    next_st = st;
    if (!run || tick) begin
      next_st.count = 16'h0000;
    end else begin
      next_st.count = st.count + 16'h0001;
    end
  end

  // restarting on idle keeps every bit phase a full quarter long
  assign tick = run && (st.count == 16'(QUARTER - 1));

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

endmodule : quarter_timer

// ### serial_host_ctrl.sv
// host controller driving the dual-mode serial control port of a decoder
//
// How it works
// R1: two-wire slave: mode low, enable high
// R2: two-wire lines idle high, released
// R3: data changes only while clock low
// R4: start is data falling, clock high
// R5: stop is data rising, clock high
// R6: eight-bit words, ninth bit acknowledges
// R7: mode pin high selects three-wire port
// R8: clock on SCK, data in, data out
// R9: enable low disables three-wire port
// R10: enable high allows three-wire transfers
// R11: both pins low resets, 100 ns least
// R12: sync string FF, FF, FE
// R13: extra FF bytes allowed, FE ends
// R14: three-wire transfers are whole bytes
// R15: enable rising edge resynchronises device
// R16: two-wire enable low resets device
// R17: enable tied high needs sync string
// R18: device samples rising, shifts falling, MSB first
`timescale 1ns/1ns
`include "serial_host_regs.svh"
module serial_host_ctrl
  import serial_host_pkg::*;
#(
  parameter int QUARTER = `SCK_QUARTER_CYCLES,
  parameter int HOLD = `RESET_HOLD_CYCLES,
  parameter int DEPTH = `ANSWER_DEPTH
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire cmd_t cmd,
  output logic rsp_valid,
  input wire logic rsp_ready,
  output rsp_t rsp,
  output logic busy,
  output logic serial_mode_select,
  output logic port_enable,
  output logic sck_out,
  output logic sck_oe_n,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic sda_in,
  input wire logic serial_out_pin
);

  typedef struct packed {
    state_t state;
    logic [1:0] phase;
    logic [3:0] bit_idx;
    logic [7:0] shift;
    logic [7:0] rx;
    op_t op;
    logic nack_last;
    logic ack_missing;
    logic [1:0] sync_left;
    logic [7:0] hold;
    logic smode;
    logic pen;
    logic sck;
    logic sda;
    pins_t pins;
    logic sda_meta;
    logic sda_sync;
    logic so_meta;
    logic so_sync;
    logic push;
    rsp_t out;
  } ctl_t;

  ctl_t st;
  ctl_t next_st;
  logic tick;
  logic run;
  logic fifo_in_ready;
  logic needs_room;
  logic sample;

  // in two-wire mode the pins are open drain: drive low or release
  function automatic pins_t drive(input logic spi, input logic sck, input logic sda);
    pins_t p;
    if (spi) begin
      p.sck_o = sck; // see R8
      p.sck_oe_n = 1'h0;
      p.sda_o = sda;
      p.sda_oe_n = 1'h0;
    end else begin
      p.sck_o = 1'h0;
      p.sck_oe_n = sck; // see R2
      p.sda_o = 1'h0;
      p.sda_oe_n = sda;
    end
    return p;
  endfunction : drive

  function automatic logic [3:0] last_bit(input logic spi);
    // three-wire bytes have no acknowledge slot
    return spi ? `BYTE_LAST_BIT : `ACK_BIT; // see R6, R14
  endfunction : last_bit

  assign run = (st.state == ST_START) || (st.state == ST_STOP) || (st.state == ST_BIT);
  assign needs_room = (cmd.op == OP_WRITE) || (cmd.op == OP_READ);
  assign cmd_ready = (st.state == ST_IDLE) && (!needs_room || fifo_in_ready);
  assign busy = (st.state != ST_IDLE);
  assign sample = st.smode ? st.so_sync : st.sda_sync;

  assign serial_mode_select = st.smode;
  assign port_enable = st.pen;
  assign sck_out = st.pins.sck_o;
  assign sck_oe_n = st.pins.sck_oe_n;
  assign sda_out = st.pins.sda_o;
  assign sda_oe_n = st.pins.sda_oe_n;

  quarter_timer #(
    .QUARTER(QUARTER)
  ) u_timer (
    .clock(clock),
    .reset_n(reset_n),
    .run(run),
    .tick(tick)
  );

  answer_fifo #(
    .WIDTH($bits(rsp_t)),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clock(clock),
    .reset_n(reset_n),
    .in_valid(st.push),
    .in_ready(fifo_in_ready),
    .in_data(st.out),
    .out_valid(rsp_valid),
    .out_ready(rsp_ready),
    .out_data(rsp)
  );

  always_comb begin
    next_st = st;
    next_st.sda_meta = sda_in;
    next_st.sda_sync = st.sda_meta;
    next_st.so_meta = serial_out_pin;
    next_st.so_sync = st.so_meta;
    next_st.push = 1'h0;
    case (st.state)
      ST_IDLE: begin
        if (cmd_valid && cmd_ready) begin
          next_st.op = cmd.op;
          next_st.phase = 2'h0;
          case (cmd.op)
            OP_MODE: begin
              next_st.smode = cmd.data[0]; // see R1, R7
              // three-wire starts disabled; two-wire needs enable held high
              next_st.pen = ~cmd.data[0]; // see R1, R9
              next_st.sck = ~cmd.data[0];
              next_st.sda = 1'h1;
            end
            OP_ENABLE: begin
              // a rise re-aligns the device to a byte boundary
              next_st.pen = cmd.data[0]; // see R10, R15, R16
            end
            OP_RESET: begin
              next_st.smode = 1'h0; // see R11
              next_st.pen = 1'h0;
              next_st.sck = 1'h1;
              next_st.sda = 1'h1;
              next_st.hold = 8'(HOLD - 1);
              next_st.state = ST_RESET;
            end
            OP_START: begin
              if (!st.smode) begin
                if (!st.sck) begin
                  next_st.sda = 1'h1; // see R3
                end
                next_st.state = ST_START;
              end
            end
            OP_STOP: begin
              if (!st.smode) begin
                next_st.sck = 1'h0;
                next_st.state = ST_STOP;
              end
            end
            OP_WRITE, OP_READ: begin
              next_st.bit_idx = 4'h0;
              next_st.ack_missing = 1'h0;
              next_st.sync_left = 2'h0;
              next_st.nack_last = cmd.last;
              next_st.sck = 1'h0;
              if (!st.smode && cmd.op == OP_READ) begin
                next_st.shift = `SYNC_FILL;
                next_st.sda = 1'h1;
              end else begin
                next_st.shift = cmd.data; // see R18
                next_st.sda = cmd.data[7];
              end
              next_st.state = ST_BIT;
            end
            OP_SYNC: begin
              if (st.smode) begin
                next_st.bit_idx = 4'h0;
                next_st.ack_missing = 1'h0;
                next_st.shift = `SYNC_FILL; // see R12
                next_st.sync_left = `SYNC_FILL_COUNT; // see R13, R17
                next_st.sck = 1'h0;
                next_st.sda = 1'h1;
                next_st.state = ST_BIT;
              end
            end
            default: begin
              next_st.state = ST_IDLE;
            end
          endcase
        end
      end
      ST_RESET: begin
        // held from the counter, never from the slow serial tick
        if (st.hold == 8'h00) begin
          next_st.pen = 1'h1; // see R11
          next_st.state = ST_IDLE;
        end else begin
          next_st.hold = st.hold - 8'h01;
        end
      end
      ST_START: begin
        if (tick) begin
          next_st.phase = st.phase + 2'h1;
          case (st.phase)
            2'h0: next_st.sck = 1'h1;
            2'h1: next_st.sda = 1'h0; // see R4
            default: begin
              next_st.sck = 1'h0;
              next_st.state = ST_IDLE;
            end
          endcase
        end
      end
      ST_STOP: begin
        if (tick) begin
          next_st.phase = st.phase + 2'h1;
          case (st.phase)
            2'h0: next_st.sda = 1'h0; // see R3
            2'h1: next_st.sck = 1'h1;
            default: begin
              next_st.sda = 1'h1; // see R5
              next_st.state = ST_IDLE;
            end
          endcase
        end
      end
      ST_BIT: begin
        if (tick) begin
          next_st.phase = st.phase + 2'h1;
          case (st.phase)
            2'h0: begin
              next_st.phase = 2'h1;
            end
            2'h1: begin
              next_st.sck = 1'h1; // see R18
            end
            2'h2: begin
              // midway through the high half, after the device's falling-edge update
              if (st.bit_idx == `ACK_BIT) begin
                next_st.ack_missing = sample; // see R6
              end else begin
                next_st.rx = {st.rx[6:0], sample}; // see R18
              end
            end
            default: begin
              next_st.sck = 1'h0; // see R3
              if (st.bit_idx == last_bit(st.smode)) begin
                if (st.sync_left != 2'h0) begin
                  next_st.sync_left = st.sync_left - 2'h1;
                  next_st.bit_idx = 4'h0;
                  if (st.sync_left == 2'h1) begin
                    next_st.shift = `SYNC_END; // see R12
                  end else begin
                    next_st.shift = `SYNC_FILL;
                  end
                  next_st.sda = 1'h1;
                end else begin
                  if (st.op != OP_SYNC) begin
                    next_st.push = 1'h1;
                    next_st.out.data = st.rx;
                    next_st.out.ack_missing = st.ack_missing;
                  end
                  next_st.state = ST_IDLE;
                end
              end else begin
                next_st.bit_idx = st.bit_idx + 4'h1;
                next_st.shift = {st.shift[6:0], 1'h0};
                if (st.bit_idx + 4'h1 == `ACK_BIT) begin
                  // reader answers; writer releases the line for the device
                  next_st.sda = (st.op == OP_READ) ? st.nack_last : 1'h1; // see R6
                end else begin
                  next_st.sda = st.shift[6];
                end
              end
            end
          endcase
        end
      end
      default: begin
        next_st.state = ST_IDLE;
      end
    endcase
    next_st.pins = drive(next_st.smode, next_st.sck, next_st.sda);
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      st <= '0;
      st.state <= ST_IDLE;
      st.op <= OP_MODE;
      st.pen <= 1'h1;
      st.sck <= 1'h1;
      st.sda <= 1'h1;
      st.pins <= '{sck_o: 1'h0, sck_oe_n: 1'h1, sda_o: 1'h0, sda_oe_n: 1'h1};
    end else begin
      st <= next_st;
    end
  end

endmodule : serial_host_ctrl

// ### serial_host_ctrl_bench.sv
// testbench for the serial port host controller against the decoder port model
`timescale 1ns/1ns
module serial_host_ctrl_bench;
  import serial_host_pkg::*;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic cmd_valid = 1'b0;
  cmd_t cmd = '0;
  logic rsp_ready = 1'b0;
  logic ack_on = 1'b1;
  logic [7:0] tx_byte = 8'hA5;
  logic cmd_ready, rsp_valid, busy, serial_mode_select, port_enable;
  logic sck_out, sck_oe_n, sda_out, sda_oe_n, serial_out_pin, pull_low;
  rsp_t rsp;
  logic [7:0] rx_byte, nbytes;
  logic [3:0] starts, stops, resets, syncs;
  int num_errors = 0;
  int total_checks = 0;
  int cycles = 0;
  // pull-ups hold both lines high unless someone drives low
  wire sck_line = sck_oe_n ? 1'b1 : sck_out;
  wire sda_line = sda_oe_n ? !pull_low : (sda_out && !pull_low);
  always #25 clock = ~clock;

  serial_host_ctrl #(.QUARTER(3), .HOLD(2), .DEPTH(8)) i_serial_host_ctrl (
    .clock(clock), .reset_n(reset_n), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd(cmd), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready), .rsp(rsp), .busy(busy),
    .serial_mode_select(serial_mode_select), .port_enable(port_enable),
    .sck_out(sck_out), .sck_oe_n(sck_oe_n), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .sda_in(sda_line), .serial_out_pin(serial_out_pin));
  decoder_port_model i_decoder_port_model (
    .sck(sck_line), .sda(sda_line), .serial_mode_select(serial_mode_select),
    .port_enable(port_enable), .ack_on(ack_on), .tx_byte(tx_byte), .pull_low(pull_low),
    .serial_out_pin(serial_out_pin), .rx_byte(rx_byte), .nbytes(nbytes), .starts(starts),
    .stops(stops), .resets(resets), .syncs(syncs));

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict

  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      $display("[FAIL] %0t timeout", $time);
      give_verdict();
    end
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check

  // offer one command, hold it until taken, then wait for the controller to go idle
  task automatic send(input op_t op, input logic [7:0] data);
    int n;
    n = 0;
    @(negedge clock);
    cmd_valid = 1'b1;
    cmd = '{op, data, 1'b0};
    #1;
    while (cmd_ready !== 1'b1 && n < 2000) begin
      @(negedge clock);
      n++;
    end
    @(negedge clock);
    cmd_valid = 1'b0;
    while (busy !== 1'b0 && n < 4000) begin
      @(negedge clock);
      n++;
    end
    @(negedge clock);
  endtask : send

  task automatic pop(input logic [8:0] exp);
    check(rsp_valid, 1'b1, "answer present");
    check(rsp, exp, "answer");
    rsp_ready = 1'b1;
    @(negedge clock);
    rsp_ready = 1'b0;
    // let an edge pass so a following pop does not re-raise ready in this step
    @(negedge clock);
  endtask : pop

  task automatic test_idle;
    check({serial_mode_select, port_enable, sck_line, sda_line}, 4'h7, "idle pins");
    check({busy, rsp_valid, cmd_ready}, 3'h1, "idle flags");
    $display("test_idle done");
  endtask : test_idle

  task automatic test_two_wire;
    send(OP_START, 8'h00);
    check(starts, 4'h1, "start");
    send(OP_WRITE, 8'h96);
    check(rx_byte, 8'h96, "first byte");
    send(OP_WRITE, 8'h3C);
    check({nbytes, rx_byte}, 16'h023C, "second byte");
    pop(9'h12C);
    pop(9'h078);
    ack_on = 1'b0;
    send(OP_WRITE, 8'h5A);
    pop(9'h0B5);
    send(OP_READ, 8'h00);
    pop(9'h1FE);
    ack_on = 1'b1;
    send(OP_STOP, 8'h00);
    check(stops, 4'h1, "stop");
    $display("test_two_wire done");
  endtask : test_two_wire

  task automatic test_hw_reset;
    send(OP_RESET, 8'h00);
    check(resets, 4'h1, "reset pulse");
    check({serial_mode_select, port_enable}, 2'h1, "pins after reset");
    send(OP_ENABLE, 8'h00);
    repeat (2) @(negedge clock);
    send(OP_ENABLE, 8'h01);
    check(resets, 4'h2, "enable low resets");
    $display("test_hw_reset done");
  endtask : test_hw_reset

  task automatic test_three_wire;
    int i;
    send(OP_MODE, 8'h01);
    check({serial_mode_select, port_enable}, 2'h2, "three-wire, port off");
    send(OP_WRITE, 8'h00);
    check(nbytes, 8'h04, "disabled port ignores clock");
    rsp_ready = 1'b1;
    @(negedge clock);
    rsp_ready = 1'b0;
    send(OP_ENABLE, 8'h01);
    // stall the answer side so the buffer fills while the string goes out
    for (i = 0; i < 8; i++) begin
      send(OP_WRITE, (i == 7) ? 8'hFE : 8'hFF);
      check(syncs, (i == 7) ? 4'h1 : 4'h0, "sync only on closing byte");
    end
    cmd_valid = 1'b1;
    cmd = '{OP_WRITE, 8'h00, 1'b0};
    repeat (3) @(negedge clock);
    check({cmd_ready, busy}, 2'h0, "full buffer refuses");
    cmd_valid = 1'b0;
    for (i = 0; i < 8; i++) pop(9'h14A);
    check(rsp_valid, 1'b0, "buffer drained");
    send(OP_SYNC, 8'h00);
    check({syncs, rsp_valid}, 5'h04, "sync string, no answer");
    send(OP_MODE, 8'h00);
    $display("test_three_wire done");
  endtask : test_three_wire

  initial begin
    repeat (16) @(negedge clock);
    reset_n = 1'b1;
    @(negedge clock);
    test_idle();
    test_two_wire();
    test_hw_reset();
    test_three_wire();
    give_verdict();
  end
endmodule : serial_host_ctrl_bench

bind serial_host_ctrl serial_host_ctrl_sva #(.QUARTER(QUARTER), .HOLD(HOLD)) i_serial_host_ctrl_sva (
  .clock(clock), .reset_n(reset_n), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd),
  .busy(busy), .serial_mode_select(serial_mode_select), .port_enable(port_enable),
  .sck_out(sck_out), .sck_oe_n(sck_oe_n), .sda_out(sda_out), .sda_oe_n(sda_oe_n));

// ### serial_host_ctrl_sva.sv
// concurrent checks on the serial port host controller's pins and command port
`timescale 1ns/1ns
module serial_host_ctrl_sva
  import serial_host_pkg::*;
#(
  parameter int QUARTER = 3,
  parameter int HOLD = 2
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire cmd_t cmd,
  input wire logic busy,
  input wire logic serial_mode_select,
  input wire logic port_enable,
  input wire logic sck_out,
  input wire logic sck_oe_n,
  input wire logic sda_out,
  input wire logic sda_oe_n
);
  op_t last_op;
  logic [3:0] edges;
  wire take = cmd_valid && cmd_ready;
  // released two-wire clock reads high through the pull-up
  wire sck_line = serial_mode_select ? sck_out : sck_oe_n;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      last_op <= OP_MODE;
      edges <= 4'h0;
    end else if (take) begin
      last_op <= cmd.op;
      edges <= 4'h0;
    end else if ($rose(sck_line)) begin
      edges <= edges + 4'h1;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  AST_OPEN_DRAIN: assert property (!serial_mode_select && $past(!serial_mode_select) |->
    (sck_oe_n || !sck_out) && (sda_oe_n || !sda_out)) else $error("two-wire pin driven high");
  AST_SCK_DRIVEN: assert property (serial_mode_select && $past(serial_mode_select) |->
    !sck_oe_n) else $error("three-wire clock not driven");
  AST_MODE_PINS: assert property (take && cmd.op == OP_MODE |=>
    serial_mode_select == $past(cmd.data[0]) && port_enable == !$past(cmd.data[0]))
    else $error("mode pins wrong");
  AST_ENABLE_PIN: assert property (take && cmd.op == OP_ENABLE |=>
    port_enable == $past(cmd.data[0])) else $error("enable pin wrong");
  AST_RESET_PINS: assert property (take && cmd.op == OP_RESET |=>
    busy && !port_enable && !serial_mode_select) else $error("reset not driven");
  AST_RESET_HOLD: assert property ($fell(port_enable) && !serial_mode_select |->
    (!port_enable && !serial_mode_select) [*2]) else $error("reset too short");
  AST_DATA_SCK_LOW: assert property (!serial_mode_select && busy && last_op == OP_WRITE &&
    $changed(sda_oe_n) |-> !sck_oe_n) else $error("data moved with clock high");
  AST_START_COND: assert property (take && cmd.op == OP_START && !serial_mode_select |->
    ##[1:40] ($fell(sda_oe_n) && sck_oe_n)) else $error("no start condition");
  AST_STOP_COND: assert property (take && cmd.op == OP_STOP && !serial_mode_select |->
    ##[1:40] ($rose(sda_oe_n) && sck_oe_n)) else $error("no stop condition");
  AST_BYTE_EDGES: assert property ($fell(busy) && (last_op == OP_WRITE || last_op == OP_READ) |->
    edges == (serial_mode_select ? 4'h8 : 4'h9)) else $error("wrong clock count");

  COV_TWO_WIRE: cover property ($fell(busy) && last_op == OP_WRITE && !serial_mode_select);
  COV_THREE_WIRE: cover property ($fell(busy) && serial_mode_select);
  COV_REFUSED: cover property (cmd_valid && !cmd_ready && !busy);
endmodule : serial_host_ctrl_sva

// ### serial_host_pkg.sv
// types shared by the serial port host controller and its user side
package serial_host_pkg;

  typedef enum logic [2:0] {
    OP_MODE = 3'b000,
    OP_ENABLE = 3'b001,
    OP_RESET = 3'b010,
    OP_START = 3'b011,
    OP_STOP = 3'b100,
    OP_WRITE = 3'b101,
    OP_READ = 3'b110,
    OP_SYNC = 3'b111
  } op_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RESET = 3'b001,
    ST_START = 3'b010,
    ST_STOP = 3'b011,
    ST_BIT = 3'b100
  } state_t;

  typedef struct packed {
    op_t op;
    logic [7:0] data;
    logic last;
  } cmd_t;

  typedef struct packed {
    logic [7:0] data;
    logic ack_missing;
  } rsp_t;

  typedef struct packed {
    logic sck_o;
    logic sck_oe_n;
    logic sda_o;
    logic sda_oe_n;
  } pins_t;

endpackage : serial_host_pkg

// ### serial_host_regs.svh
// timing counts and fixed byte values for the serial port host controller
`ifndef SERIAL_HOST_REGS_SVH
`define SERIAL_HOST_REGS_SVH

// system clock period
`define CLK_PERIOD_NS 50

// least time both select pins stay low for a hardware reset
`define RESET_HOLD_NS 100
`define RESET_HOLD_CYCLES ((`RESET_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// one quarter of a serial clock period (10 us period, 100 kHz)
`define SCK_QUARTER_NS 2500
`define SCK_QUARTER_CYCLES (`SCK_QUARTER_NS / `CLK_PERIOD_NS)

// byte synchronisation string: fill bytes, then the closing byte
`define SYNC_FILL 8'hFF
`define SYNC_END 8'hFE
`define SYNC_FILL_COUNT 2'h2

// bit positions inside a transfer: last bit of a three-wire byte, two-wire acknowledge bit
`define BYTE_LAST_BIT 4'h7
`define ACK_BIT 4'h8

// depth of the answer buffer
`define ANSWER_DEPTH 8

`endif
